// >>> core/tsrb_bank.sv
/*
 * Status and result register bank of an eight-channel proximity and touch controller:
 * channel state words, counts, baselines, deltas, slider coordinates and the
 * power and system settings word with its command bits.
 * Assumes the serial engine hands over byte accesses by word address, and the
 * sensing engine delivers events and results as one-cycle strobes on core_clk.
 */
`timescale 1ns/1ps
module tsrb_bank (
   input  wire logic                    core_clk,        // Core clock, 200 MHz
   input  wire logic                    reset,           // Synchronous reset, active high
   input  wire tsrb_pkg::tsrb_host_req_t host_req,       // Host byte access
   output logic      [7:0]              rd_data_q,       // Read byte
   output logic                         rd_valid_q,      // Read byte valid, one cycle
   input  wire logic                    prox_evt,        // Proximity event strobe
   input  wire logic [7:0]              prox_state,      // Proximity state per channel
   input  wire logic [7:0]              dir_cross,       // Threshold crossing per channel
   input  wire logic [7:0]              dir_above,       // Count above baseline per channel
   input  wire logic                    touch_evt,       // Touch event strobe
   input  wire logic [7:0]              touch_state,     // Touch state per channel
   input  wire logic                    deep_evt,        // Deep touch event strobe
   input  wire logic [7:0]              deep_state,      // Deep touch state per channel
   input  wire logic                    ref_evt,         // Reference channel event strobe
   input  wire logic [7:0]              ref_usage,       // Reference channels in use
   input  wire tsrb_pkg::tsrb_sample_t   sample,          // Channel result strobe
   input  wire logic [1:0][7:0]         slider_members,  // Channels of each slider
   input  wire logic                    coord_valid,     // Coordinates computed strobe
   input  wire logic [1:0][7:0]         coord,           // Computed coordinates
   input  wire logic                    wake_sample,     // Wake channel sampled strobe
   input  wire logic                    in_deepest_power,// Deepest power state active
   input  wire logic                    sample_done,     // Sampling cycle finished strobe
   input  wire logic                    unmasked_evt,    // Unmasked event this cycle
   input  wire logic                    comms_done,      // Host ended the window
   output logic      [15:0]             settings_q,      // Stored settings word
   output logic                         slider_stream_q, // Stream slider detail
   output logic                         full_update_q,   // Update all channels, one cycle
   output logic                         rdy_window_q,    // Ready window open, level
   output logic                         restart_flag_q,  // Restart indicator
   output logic                         redo_ati_q,      // Retune command, one cycle
   output logic                         soft_reset_q     // Soft reset command, one cycle
);

   // Channel result stores
   logic [15:0] count_mem [8];
   logic [15:0] base_mem  [8];
   logic [15:0] delta_mem [8];
   logic [15:0] refd_mem  [8];

   // State bytes
   logic [7:0]  prox_q;
   logic [7:0]  dir_q;
   logic [7:0]  touch_q;
   logic [7:0]  deep_q;
   logic [7:0]  refuse_q;

   // Slider, update-rate and ready-window state
   logic [1:0][7:0]  slider_q;
   logic [1:0]       slider_touched;
   logic [7:0]       ulp_cnt_q;
   logic [7:0]       ulp_n;
   tsrb_pkg::tsrb_win_state_t win_q;

   // Decode helpers
   logic        wr_set;
   logic        ack_wr;
   logic [15:0] rd_word;
   logic [7:0]  cnt_idx;

   // Proximity byte, refreshed whole on every proximity event
   tsrb_state_byte #(
      .W        (8)
   ) u_prox (
      .core_clk (core_clk),
      .reset    (reset),
      .load_en  ({8{prox_evt}}),
      .load_val (prox_state),
      .state_q  (prox_q)
   );

   // Direction bits move only on their own channel's crossing
   tsrb_state_byte #(
      .W        (8)
   ) u_dir (
      .core_clk (core_clk),
      .reset    (reset),
      .load_en  (dir_cross),
      .load_val (dir_above),
      .state_q  (dir_q)
   );

   // Touch byte
   tsrb_state_byte #(
      .W        (8)
   ) u_touch (
      .core_clk (core_clk),
      .reset    (reset),
      .load_en  ({8{touch_evt}}),
      .load_val (touch_state),
      .state_q  (touch_q)
   );

   // Deep touch byte
   tsrb_state_byte #(
      .W        (8)
   ) u_deep (
      .core_clk (core_clk),
      .reset    (reset),
      .load_en  ({8{deep_evt}}),
      .load_val (deep_state),
      .state_q  (deep_q)
   );

   // Reference usage byte
   tsrb_state_byte #(
      .W        (8)
   ) u_refuse (
      .core_clk (core_clk),
      .reset    (reset),
      .load_en  ({8{ref_evt}}),
      .load_val (ref_usage),
      .state_q  (refuse_q)
   );

   // Channel results; delta formed here so it always matches the stored pair
   always_ff @(posedge core_clk) begin
      if (reset) begin
         for (int i = 0; i < 8; i++) begin
            count_mem[i] <= tsrb_pkg::WORD_RST;
            base_mem[i]  <= tsrb_pkg::WORD_RST;
            delta_mem[i] <= tsrb_pkg::WORD_RST;
            refd_mem[i]  <= tsrb_pkg::WORD_RST;
         end
      end else if (sample.valid) begin
         count_mem[sample.chan] <= sample.count;
         base_mem[sample.chan]  <= sample.baseline;
         delta_mem[sample.chan] <= sample.baseline - sample.count;
         refd_mem[sample.chan]  <= sample.ref_delta;
      end
   end

   // A slider counts as touched when any of its channels is in touch
   always_comb begin
      for (int s = 0; s < 2; s++) begin
         slider_touched[s] = |(touch_q & slider_members[s]);
      end
   end

   // Coordinates follow the finger and freeze on release
   always_ff @(posedge core_clk) begin
      if (reset) begin
         slider_q <= '0;
      end else begin
         for (int s = 0; s < 2; s++) begin
            if (coord_valid && slider_touched[s]) begin
               slider_q[s] <= coord[s];
            end
         end
      end
   end
   // Only reset clears it, so the last coordinate holds until the next touched update or reset

   // Settings writes: only the settings word is writable
   assign wr_set = host_req.wr && (host_req.addr == tsrb_pkg::ADDR_SETTINGS);
   assign ack_wr = wr_set && host_req.byte_sel
                   && host_req.wdata[tsrb_pkg::SET_ACK_RESET_BIT - 8];

   // Settings word; command bits never stored, soft reset restores defaults
   always_ff @(posedge core_clk) begin
      if (reset || soft_reset_q) begin
         settings_q <= tsrb_pkg::SETTINGS_RST;
      end else if (wr_set) begin
         if (host_req.byte_sel) begin
            settings_q[15:8] <= host_req.wdata & ~tsrb_pkg::SET_CMD_MASK[15:8];
         end else begin
            settings_q[7:0]  <= host_req.wdata;
         end
      end
   end

   // Command pulses last one cycle
   always_ff @(posedge core_clk) begin
      if (reset) begin
         redo_ati_q   <= 1'b0;
         soft_reset_q <= 1'b0;
      end else begin
         redo_ati_q   <= wr_set && host_req.byte_sel
                         && host_req.wdata[tsrb_pkg::SET_REDO_ATI_BIT - 8];
         soft_reset_q <= wr_set && host_req.byte_sel
                         && host_req.wdata[tsrb_pkg::SET_SOFT_RESET_BIT - 8];
      end
   end

   // Restart indicator: set by any reset, cleared by the acknowledge;
   // a soft reset in the same cycle as an acknowledge wins
   always_ff @(posedge core_clk) begin
      if (reset) begin
         restart_flag_q <= 1'b1;
      end else if (soft_reset_q) begin
         restart_flag_q <= 1'b1;
      end else if (ack_wr) begin
         restart_flag_q <= 1'b0;
      end
   end

   // Slider streaming follows its settings bit
   always_ff @(posedge core_clk) begin
      if (reset) begin
         slider_stream_q <= 1'b0;
      end else begin
         slider_stream_q <= settings_q[tsrb_pkg::SET_SLIDER_STR_BIT];
      end
   end

   // Full update every n wake samples; count restarts outside deepest power
   assign ulp_n = tsrb_pkg::ulp_period(
                     settings_q[tsrb_pkg::SET_ULP_RATE_LSB +: 3]);

   always_ff @(posedge core_clk) begin
      if (reset || !in_deepest_power) begin
         ulp_cnt_q     <= tsrb_pkg::ULP_CNT_RST;
         full_update_q <= 1'b0;
      end else if (wake_sample) begin
         if (ulp_cnt_q + 8'h01 >= ulp_n) begin
            ulp_cnt_q     <= tsrb_pkg::ULP_CNT_RST;
            full_update_q <= 1'b1;
         end else begin
            ulp_cnt_q     <= ulp_cnt_q + 8'h01;
            full_update_q <= 1'b0;
         end
      end else begin
         full_update_q <= 1'b0;
      end
   end

   // Ready window: streaming opens after each sample that ends while it is closed, event mode only on events.
   // The window stays open until the host ends it; samples ending while it is open open no further window.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         win_q        <= tsrb_pkg::TSRB_WIN_IDLE;
         rdy_window_q <= 1'b0;
      end else begin
         case (win_q)
            tsrb_pkg::TSRB_WIN_IDLE: begin
               if (sample_done && (!settings_q[tsrb_pkg::SET_EVENT_MODE_BIT]
                                   || unmasked_evt)) begin
                  win_q        <= tsrb_pkg::TSRB_WIN_OPEN;
                  rdy_window_q <= 1'b1;
               end
            end
            tsrb_pkg::TSRB_WIN_OPEN: begin
               if (comms_done) begin
                  win_q        <= tsrb_pkg::TSRB_WIN_IDLE;
                  rdy_window_q <= 1'b0;
               end
            end
            default: begin
               win_q        <= tsrb_pkg::TSRB_WIN_IDLE;
               rdy_window_q <= 1'b0;
            end
         endcase
      end
   end

   // Word select for reads; unmapped and reserved addresses give zero
   assign cnt_idx = host_req.addr - tsrb_pkg::ADDR_CNT_FIRST;

   always_comb begin
      rd_word = tsrb_pkg::WORD_RST;
      if (host_req.addr == tsrb_pkg::ADDR_PROX_DIR) begin
         rd_word = {dir_q, prox_q};
      end else if (host_req.addr == tsrb_pkg::ADDR_TOUCH_DEEP) begin
         rd_word = {deep_q, touch_q};
      end else if (host_req.addr == tsrb_pkg::ADDR_REF_USAGE) begin
         rd_word = {8'h00, refuse_q};
      end else if (host_req.addr >= tsrb_pkg::ADDR_CNT_FIRST
                   && host_req.addr <= tsrb_pkg::ADDR_CNT_LAST) begin
         // Even address is the count, odd the baseline of the same channel
         rd_word = cnt_idx[0] ? base_mem[cnt_idx[3:1]] : count_mem[cnt_idx[3:1]];
      end else if (host_req.addr >= tsrb_pkg::ADDR_DLT_FIRST
                   && host_req.addr <= tsrb_pkg::ADDR_DLT_LAST) begin
         rd_word = delta_mem[host_req.addr[2:0]];
      end else if (host_req.addr >= tsrb_pkg::ADDR_REFD_FIRST
                   && host_req.addr <= tsrb_pkg::ADDR_REFD_LAST) begin
         rd_word = refd_mem[host_req.addr[2:0]];
      end else if (host_req.addr == tsrb_pkg::ADDR_SLIDER) begin
         rd_word = {slider_q[1], slider_q[0]};
      end else if (host_req.addr == tsrb_pkg::ADDR_SETTINGS) begin
         rd_word = settings_q;
      end
   end

   // Byte lane select and registered read answer
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rd_data_q  <= tsrb_pkg::STATE_RST;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= host_req.rd;
         if (host_req.rd) begin
            rd_data_q <= host_req.byte_sel ? rd_word[15:8] : rd_word[7:0];
         end
      end
   end

endmodule : tsrb_bank

// >>> include/tsrb_pkg.sv
/*
 * Package of the touch status register bank: register offsets, settings word field
 * positions, reset values, update-rate counts and the structs carried on the ports.
 * Assumes a single core clock domain and byte-wide host access by word address.
 */
package tsrb_pkg;

   // Word addresses of the status and result map
   localparam logic [7:0] ADDR_PROX_DIR   = 8'h04;
   localparam logic [7:0] ADDR_TOUCH_DEEP = 8'h05;
   localparam logic [7:0] ADDR_REF_USAGE  = 8'h06;
   localparam logic [7:0] ADDR_RSVD_STATE = 8'h07;
   localparam logic [7:0] ADDR_CNT_FIRST  = 8'h08;
   localparam logic [7:0] ADDR_CNT_LAST   = 8'h17;
   localparam logic [7:0] ADDR_DLT_FIRST  = 8'h18;
   localparam logic [7:0] ADDR_DLT_LAST   = 8'h1f;
   localparam logic [7:0] ADDR_REFD_FIRST = 8'h20;
   localparam logic [7:0] ADDR_REFD_LAST  = 8'h27;
   localparam logic [7:0] ADDR_SLIDER     = 8'h30;
   localparam logic [7:0] ADDR_SETTINGS   = 8'h80;

   // Settings word fields, low byte
   localparam int SET_ULP_RATE_LSB   = 0;
   localparam int SET_PWR_SEL_LSB    = 3;
   localparam int SET_AUTO_PWR_BIT   = 5;
   localparam int SET_ULP_EN_BIT     = 6;
   localparam int SET_OSC_BIT        = 7;
   // Settings word fields, high byte
   localparam int SET_ACK_RESET_BIT  = 8;
   localparam int SET_SOFT_RESET_BIT = 9;
   localparam int SET_REDO_ATI_BIT   = 10;
   localparam int SET_COMMS_ATI_BIT  = 11;
   localparam int SET_SLIDER_STR_BIT = 12;
   localparam int SET_EVENT_MODE_BIT = 13;
   localparam int SET_COMMS_NP_BIT   = 14;
   localparam int SET_SLIDER_UI_BIT  = 15;

   // Command bits never store; they read back as zero
   localparam logic [15:0] SET_CMD_MASK  = 16'h0700;

   // Reset values
   localparam logic [15:0] SETTINGS_RST  = 16'h0000;
   localparam logic [7:0]  STATE_RST     = 8'h00;
   localparam logic [15:0] WORD_RST      = 16'h0000;
   localparam logic [7:0]  ULP_CNT_RST   = 8'h00;

   // Wake-channel samples between full updates, per rate code
   localparam logic [7:0] ULP_N_000 = 8'd2;
   localparam logic [7:0] ULP_N_001 = 8'd4;
   localparam logic [7:0] ULP_N_010 = 8'd8;
   localparam logic [7:0] ULP_N_011 = 8'd16;
   localparam logic [7:0] ULP_N_100 = 8'd32;
   localparam logic [7:0] ULP_N_101 = 8'd64;
   localparam logic [7:0] ULP_N_110 = 8'd128;
   localparam logic [7:0] ULP_N_111 = 8'd255;

   // Host byte access as handed over by the serial engine
   typedef struct packed {
      logic       rd;       // Read strobe, one cycle
      logic       wr;       // Write strobe, one cycle
      logic [7:0] addr;     // Word address
      logic       byte_sel; // Item offset: 0 low byte, 1 high byte
      logic [7:0] wdata;    // Write byte
   } tsrb_host_req_t;

   // One channel result from the sensing engine
   typedef struct packed {
      logic        valid;     // One-cycle strobe
      logic [2:0]  chan;      // Channel index
      logic [15:0] count;     // Filtered count
      logic [15:0] baseline;  // Slow baseline
      logic [15:0] ref_delta; // Weighted reference shift, signed
   } tsrb_sample_t;

   // Ready-window sequencer
   typedef enum logic [1:0] {
      TSRB_WIN_IDLE = 2'b01,
      TSRB_WIN_OPEN = 2'b10
   } tsrb_win_state_t;

   // Update-rate code to sample count
   function automatic logic [7:0] ulp_period(input logic [2:0] code);
      logic [7:0] n;
      case (code)
         3'h0:    n = ULP_N_000;
         3'h1:    n = ULP_N_001;
         3'h2:    n = ULP_N_010;
         3'h3:    n = ULP_N_011;
         3'h4:    n = ULP_N_100;
         3'h5:    n = ULP_N_101;
         3'h6:    n = ULP_N_110;
         default: n = ULP_N_111;
      endcase
      return n;
   endfunction : ulp_period

endpackage : tsrb_pkg

// >>> core/tsrb_state_byte.sv
/*
 * Per-bit loadable state byte: each bit takes its new value only when its own
 * load enable is high, otherwise it holds.
 * Assumes load enables and values come from logic on the same clock.
 */
`timescale 1ns/1ps
module tsrb_state_byte #(
   parameter int W = 8
) (
   input  wire logic         core_clk, // Core clock
   input  wire logic         reset,    // Synchronous reset, active high
   input  wire logic [W-1:0] load_en,  // Per-bit load enable
   input  wire logic [W-1:0] load_val, // Per-bit new value
   output logic      [W-1:0] state_q   // Held state
);

   // Bitwise merge so one event can refresh some bits and leave the rest
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q <= W'(tsrb_pkg::STATE_RST);
      end else begin
         state_q <= (load_en & load_val) | (~load_en & state_q);
      end
   end

endmodule : tsrb_state_byte

// >>> testbench/tsrb_bank_asserts.sv
/* Checker for tsrb_bank: read answer timing, settings writes and commands,
   ready window and deepest-power updates.
   Assumes it is bound to tsrb_bank and sees only that module's ports. */
`timescale 1ns/1ps
module tsrb_bank_asserts (
   input wire logic                     core_clk,         // Clock
   input wire logic                     reset,            // Sync reset
   input wire tsrb_pkg::tsrb_host_req_t host_req,         // Host access
   input wire logic                     rd_valid_q,       // Read valid
   input wire logic [15:0]              settings_q,       // Settings
   input wire logic                     slider_stream_q,  // Stream flag
   input wire logic                     full_update_q,    // Full update
   input wire logic                     wake_sample,      // Wake sample
   input wire logic                     in_deepest_power, // Deep power
   input wire logic                     sample_done,      // Sample end
   input wire logic                     unmasked_evt,     // Event cause
   input wire logic                     comms_done,       // Window end
   input wire logic                     rdy_window_q,     // Window
   input wire logic                     restart_flag_q,   // Restart flag
   input wire logic                     soft_reset_q      // Soft reset
);
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (reset);

   // Settings write that is not swallowed by a soft reset in flight
   sequence set_wr(logic hi);
      host_req.wr && host_req.addr == tsrb_pkg::ADDR_SETTINGS
         && host_req.byte_sel == hi && !soft_reset_q;
   endsequence
   // Sample end that should open the window
   sequence win_cause;
      sample_done && !rdy_window_q && !comms_done
         && (!settings_q[tsrb_pkg::SET_EVENT_MODE_BIT] || unmasked_evt);
   endsequence

   rd_answer_a: assert property (host_req.rd |=> rd_valid_q)
      else $error("read not answered one cycle later");
   rd_single_a: assert property (!host_req.rd |=> !rd_valid_q)
      else $error("read valid without a read");
   low_write_a: assert property (set_wr(1'b0) |=> settings_q[7:0] == $past(host_req.wdata))
      else $error("settings low byte not written");
   cmd_zero_a: assert property (settings_q[10:8] == 3'h0)
      else $error("command bits stored");
   ro_write_a: assert property (host_req.wr && host_req.addr != tsrb_pkg::ADDR_SETTINGS
      && !soft_reset_q |=> $stable(settings_q))
      else $error("read-only write changed settings");
   ack_clear_a: assert property (set_wr(1'b1) && host_req.wdata[0] && !host_req.wdata[1]
      |=> !restart_flag_q)
      else $error("acknowledge left restart flag set");
   soft_rst_a: assert property (set_wr(1'b1) && host_req.wdata[1] |=> soft_reset_q
      ##1 (settings_q == tsrb_pkg::SETTINGS_RST && restart_flag_q))
      else $error("soft reset sequence wrong");
   stream_bit_a: assert property (slider_stream_q
      == $past(settings_q[tsrb_pkg::SET_SLIDER_STR_BIT]))
      else $error("slider stream flag does not follow settings");
   win_open_a: assert property (win_cause |=> rdy_window_q)
      else $error("ready window not opened");
   win_block_a: assert property (sample_done && !rdy_window_q && !unmasked_evt
      && settings_q[tsrb_pkg::SET_EVENT_MODE_BIT] |=> !rdy_window_q)
      else $error("window opened without unmasked event");
   win_close_a: assert property (comms_done && rdy_window_q |=> !rdy_window_q)
      else $error("window not closed");
   full_cause_a: assert property (full_update_q |-> $past(wake_sample)
      && $past(in_deepest_power))
      else $error("full update without wake sample");
endmodule : tsrb_bank_asserts

// >>> testbench/tsrb_host_model.sv
/* Host side of the bank: byte reads and writes by word address, word
   reads and the host's own delta arithmetic.
   Assumes one calling process and the one-cycle strobe hand-over. */
`timescale 1ns/1ps
module tsrb_host_model (
   input  wire logic               core_clk,   // Core clock
   output tsrb_pkg::tsrb_host_req_t req,        // Byte access
   input  wire logic [7:0]         rd_data_q,  // Read byte
   input  wire logic               rd_valid_q  // Read byte valid
);
   initial req = '0;

   // One strobe cycle; idle fields inverted so stale values never pass
   task automatic access(input logic rd, input logic [7:0] a, input logic s,
                         input logic [7:0] d);
      @(posedge core_clk);
      req <= '{rd: rd, wr: !rd, addr: a, byte_sel: s, wdata: d};
      @(posedge core_clk);
      req <= '{rd: 1'h0, wr: 1'h0, addr: ~a, byte_sel: ~s, wdata: ~d};
   endtask : access

   task automatic wr_byte(input logic [7:0] a, input logic s, input logic [7:0] d);
      access(1'h0, a, s, d);
   endtask : wr_byte

   // Answer is due exactly one cycle after the strobe is taken
   task automatic rd_byte(input logic [7:0] a, input logic s, output logic [7:0] d);
      access(1'h1, a, s, 8'h00);
      #1;
      d = rd_valid_q ? rd_data_q : 8'hxx;
   endtask : rd_byte

   task automatic rd_word(input logic [7:0] a, output logic [15:0] w);
      rd_byte(a, 1'h0, w[7:0]);
      rd_byte(a, 1'h1, w[15:8]);
   endtask : rd_word

   // Delta from count and baseline, for parts whose reported delta is off
   task automatic host_delta(input logic [2:0] k, output logic [15:0] dl);
      logic [15:0] c;
      logic [15:0] b;
      rd_word(8'h08 + {4'h0, k, 1'h0}, c);
      rd_word(8'h09 + {4'h0, k, 1'h0}, b);
      dl = b - c;
   endtask : host_delta
endmodule : tsrb_host_model

// >>> testbench/tsrb_bank_tb.sv
/* Self-checking bench for tsrb_bank: sensing strobes driven by hand,
   registers reached through the host model.
   Assumes a 5 ns core clock and synchronous active-high reset. */
`timescale 1ns/1ps
module tsrb_bank_tb;
   logic core_clk = 1'h0, reset = 1'h1, rd_valid_q, slider_stream_q, full_update_q;
   logic rdy_window_q, restart_flag_q, redo_ati_q, soft_reset_q;
   logic prox_evt = 1'h0, touch_evt = 1'h0, deep_evt = 1'h0, ref_evt = 1'h0;
   logic coord_valid = 1'h0, wake_sample = 1'h0, in_deepest_power = 1'h0;
   logic sample_done = 1'h0, unmasked_evt = 1'h0, comms_done = 1'h0;
   logic [7:0] rd_data_q, prox_state = '0, dir_cross = '0, dir_above = '0;
   logic [7:0] touch_state = '0, deep_state = '0, ref_usage = '0;
   logic [15:0] settings_q;
   logic [1:0][7:0] slider_members = '0, coord = '0;
   tsrb_pkg::tsrb_host_req_t host_req;
   tsrb_pkg::tsrb_sample_t sample = '0;
   int error_cnt = 0, checks = 0, cyc = 0;

   tsrb_bank dut (.core_clk, .reset, .host_req, .rd_data_q, .rd_valid_q, .prox_evt,
      .prox_state, .dir_cross, .dir_above, .touch_evt, .touch_state, .deep_evt,
      .deep_state, .ref_evt, .ref_usage, .sample, .slider_members, .coord_valid, .coord,
      .wake_sample, .in_deepest_power, .sample_done, .unmasked_evt, .comms_done,
      .settings_q, .slider_stream_q, .full_update_q, .rdy_window_q, .restart_flag_q,
      .redo_ati_q, .soft_reset_q);
   tsrb_host_model host (.core_clk, .req(host_req), .rd_data_q, .rd_valid_q);

   // Clock and hang guard; a hang ends the run as a failure
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         stop_test;
      end
   end

   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic rdw(input logic [7:0] a, input logic [15:0] exp, input string nm);
      logic [15:0] w;
      host.rd_word(a, w);
      chk(nm, w, exp);
   endtask : rdw

   // Event strobes in order prox, touch, deep, ref, with their state bytes
   task automatic ev(input logic [3:0] e, input logic [7:0] p, dc, da, t, dp, r);
      @(posedge core_clk);
      {prox_evt, touch_evt, deep_evt, ref_evt} <= e;
      {prox_state, dir_cross, dir_above, touch_state, deep_state, ref_usage} <= {p, dc, da, t, dp, r};
      @(posedge core_clk);
      {prox_evt, touch_evt, deep_evt, ref_evt, dir_cross} <= '0;
   endtask : ev

   // Window causes, then one settle cycle before the caller looks
   task automatic win(input logic s, input logic c, input logic u);
      @(posedge core_clk);
      {sample_done, comms_done, unmasked_evt} <= {s, c, u};
      @(posedge core_clk);
      {sample_done, comms_done, unmasked_evt} <= '0;
      @(posedge core_clk);
   endtask : win

   task automatic t_states;
      rdw(8'h07, 16'h0000, "reserved");
      rdw(8'h41, 16'h0000, "unmapped");
      ev(4'hf, 8'h81, 8'h03, 8'h01, 8'h24, 8'h20, 8'h42);
      rdw(8'h04, 16'h0181, "prox_dir");
      rdw(8'h05, 16'h2024, "touch_deep");
      rdw(8'h06, 16'h0042, "ref_usage");
      ev(4'h8, 8'h10, 8'h02, 8'h02, 8'hff, 8'hff, 8'h00);
      rdw(8'h04, 16'h0310, "dir_only");
      rdw(8'h05, 16'h2024, "touch_held");
      rdw(8'h06, 16'h0042, "ref_held");
   endtask : t_states

   task automatic t_results;
      logic [15:0] c;
      logic [15:0] hd;
      for (int k = 0; k < 8; k++) begin
         @(posedge core_clk);
         sample <= '{1'h1, k[2:0], {k[7:0], 8'h50}, 16'h0300, {13'h1ffe, k[2:0]}};
      end
      @(posedge core_clk);
      sample.valid <= 1'h0;
      host.wr_byte(8'h18, 1'h0, 8'hff);
      for (int k = 0; k < 8; k++) begin
         c = {k[7:0], 8'h50};
         rdw(8'h08 + 8'(2 * k), c, "count");
         rdw(8'h09 + 8'(2 * k), 16'h0300, "baseline");
         rdw(8'h18 + 8'(k), 16'h0300 - c, "delta");
         host.host_delta(k[2:0], hd);
         chk("host_delta", hd, 16'h0300 - c);
         rdw(8'h20 + 8'(k), {13'h1ffe, k[2:0]}, "ref_delta");
      end
   endtask : t_results

   task automatic t_slider;
      logic [3:0][15:0] cin;
      logic [3:0][7:0] tch;
      logic [3:0][15:0] exp;
      cin = {16'h5566, 16'h3344, 16'h1122, 16'h9a35};
      tch = {8'h20, 8'h00, 8'h04, 8'h24};
      exp = {16'h5522, 16'h9a22, 16'h9a22, 16'h9a35};
      slider_members <= {8'hf0, 8'h0f};
      for (int i = 0; i < 4; i++) begin
         ev(4'h4, 8'h10, 8'h00, 8'h00, tch[i], 8'h20, 8'h00);
         @(posedge core_clk);
         {coord_valid, coord} <= {1'h1, cin[i]};
         @(posedge core_clk);
         coord_valid <= 1'h0;
         rdw(8'h30, exp[i], "slider");
      end
   endtask : t_slider

   task automatic t_settings;
      host.wr_byte(8'h80, 1'h0, 8'hc3);
      host.wr_byte(8'h80, 1'h1, 8'h18);
      host.wr_byte(8'h04, 1'h0, 8'h00);
      rdw(8'h80, 16'h18c3, "settings");
      chk("stream", slider_stream_q, 16'h0001);
      rdw(8'h04, 16'h0310, "ro_write");
      host.wr_byte(8'h80, 1'h1, 8'h29);
      @(posedge core_clk);
      chk("restart_ack", restart_flag_q, 16'h0000);
      rdw(8'h80, 16'h28c3, "ack_not_kept");
      win(1'h1, 1'h0, 1'h0);
      chk("win_masked", rdy_window_q, 16'h0000);
      win(1'h1, 1'h0, 1'h1);
      chk("win_event", rdy_window_q, 16'h0001);
      win(1'h0, 1'h1, 1'h0);
      chk("win_closed", rdy_window_q, 16'h0000);
      host.wr_byte(8'h80, 1'h1, 8'h02);
      @(posedge core_clk);
      @(posedge core_clk);
      chk("soft_reset", {restart_flag_q, settings_q[14:0]}, 16'h8000);
      win(1'h1, 1'h0, 1'h0);
      chk("win_stream", rdy_window_q, 16'h0001);
      win(1'h0, 1'h1, 1'h0);
   endtask : t_settings

   // Every update-rate code: silence until the n-th wake sample
   task automatic t_ulp;
      int n;
      for (int code = 0; code < 8; code++) begin
         n = (code == 7) ? 255 : 2 << code;
         host.wr_byte(8'h80, 1'h0, {5'h08, code[2:0]});
         in_deepest_power <= 1'h1;
         for (int i = 1; i <= n; i++) begin
            wake_sample <= 1'h1;
            @(posedge core_clk);
            wake_sample <= 1'h0;
            #1 chk("full_update", full_update_q, {15'h0000, i == n});
            @(posedge core_clk);
         end
         in_deepest_power <= 1'h0;
      end
   endtask : t_ulp

   task automatic stop_test;
      if (error_cnt == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test

   // Reset, then the scenarios in turn
   initial begin
      repeat (16) @(posedge core_clk);
      reset <= 1'h0;
      @(posedge core_clk);
      chk("restart_rst", restart_flag_q, 16'h0001);
      t_states;
      t_results;
      t_slider;
      t_settings;
      t_ulp;
      stop_test;
   end
endmodule : tsrb_bank_tb

bind tsrb_bank tsrb_bank_asserts u_chk (.core_clk, .reset, .host_req, .rd_valid_q,
   .settings_q, .slider_stream_q, .full_update_q, .wake_sample, .in_deepest_power,
   .sample_done, .unmasked_evt, .comms_done, .rdy_window_q, .restart_flag_q,
   .soft_reset_q);
